// ==== rtl/step_out_pkg.sv ====
// constants and carrier types for the stepper phase output stage
// assumes a single 100 MHz clock domain
package step_out_pkg;
  localparam int unsigned clk_period_ns = 10;
  localparam logic [3:0] home_pattern = 4'h5;
  localparam int unsigned osc_half_default = 2500;
  localparam int unsigned ghost_delay_default = 5000;
  localparam int unsigned phase_a_bit = 3;
  localparam int unsigned phase_b_bit = 2;
  localparam int unsigned phase_c_bit = 1;
  localparam int unsigned phase_d_bit = 0;

  typedef struct packed {
    logic [3:0] phases;
    logic ab_pair_disable_n;
    logic cd_pair_disable_n;
  } drive_type;

  typedef struct packed {
    logic o;
    logic oe;
  } pin_drive_type;
endpackage

// ==== rtl/stepper_phase_output_logic.sv ====
// output stage of a stepper controller: phase/disable gating, chopper, sync clock,
// origin indicator and optional step doubler
// assumes translator phases arrive on clk; pin inputs are asynchronous
`timescale 1ns/1ps
module stepper_phase_output_logic
  import step_out_pkg::*;
#(
  parameter int unsigned osc_half_cycles = osc_half_default,
  parameter int unsigned ghost_delay_cycles = ghost_delay_default,
  parameter bit doubler_on = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // translator side
  input wire logic [3:0] translator_phases,
  input wire logic step_in,
  output logic step_out,
  // pins from outside
  input wire logic enable_pin,
  input wire logic control_pin,
  input wire logic ab_current_sense,
  input wire logic cd_current_sense,
  input wire logic sync_master,
  input wire logic sync_in,
  // pins to power bridge
  output logic [3:0] phases,
  output logic ab_pair_disable_n,
  output logic cd_pair_disable_n,
  // sync pin drive and origin open collector
  output logic sync_o,
  output logic sync_oe,
  output logic origin_o,
  output logic origin_oe
);
  // three-stage synchronisers; stage 1 only feeds stage 2
  logic [4:0] sy1;
  logic [4:0] sy2;
  logic [4:0] sy3;
  logic [4:0] raw_in;
  logic [4:0] stable;
  assign raw_in = {enable_pin, control_pin, ab_current_sense, cd_current_sense, sync_in};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          sy1[gi] <= 1'b0;
          sy2[gi] <= 1'b0;
          sy3[gi] <= 1'b0;
          stable[gi] <= 1'b0;
        end else begin
          sy1[gi] <= raw_in[gi];
          sy2[gi] <= sy1[gi];
          sy3[gi] <= sy2[gi];
          if (sy2[gi] == sy3[gi]) begin
            stable[gi] <= sy3[gi];
          end
        end
      end
    end
  endgenerate

  wire en_s = stable[4];
  wire ctl_s = stable[3];
  wire ab_trip = stable[2];
  wire cd_trip = stable[1];
  wire ext_sync = stable[0];

  // on-chip oscillator square wave
  logic [31:0] osc_cnt;
  logic osc_sq;
  wire osc_wrap = (osc_cnt >= osc_half_cycles - 1);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_cnt <= '0;
      osc_sq <= 1'b0;
    end else if (osc_wrap) begin
      osc_cnt <= '0;
      osc_sq <= ~osc_sq;
    end else begin
      osc_cnt <= osc_cnt + 32'h0000_0001;
    end
  end

  // slaves take the shared pin as their chopper clock
  wire chop_clk_lvl = sync_master ? osc_sq : ext_sync;
  logic chop_clk_d;
  wire chop_pulse = chop_clk_lvl & ~chop_clk_d;

  // chopper flops: set by clock pulse, reset by trip; trip wins
  logic ab_chop_on;
  logic cd_chop_on;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chop_clk_d <= 1'b0;
      ab_chop_on <= 1'b0;
      cd_chop_on <= 1'b0;
    end else begin
      chop_clk_d <= chop_clk_lvl;
      if (ab_trip) begin
        ab_chop_on <= 1'b0;
      end else if (chop_pulse) begin
        ab_chop_on <= 1'b1;
      end
      if (cd_trip) begin
        cd_chop_on <= 1'b0;
      end else if (chop_pulse) begin
        cd_chop_on <= 1'b1;
      end
    end
  end

  // output decode
  wire pa = translator_phases[phase_a_bit];
  wire pb = translator_phases[phase_b_bit];
  wire pc = translator_phases[phase_c_bit];
  wire pd = translator_phases[phase_d_bit];
  wire ab_off = ~ab_chop_on;
  wire cd_off = ~cd_chop_on;
  // phase chopping raises the low partner so current recirculates above sense
  wire ab_phase_chop = ctl_s & ab_off;
  wire cd_phase_chop = ctl_s & cd_off;
  wire ab_inh_chop = ~ctl_s & ab_off;
  wire cd_inh_chop = ~ctl_s & cd_off;
  wire na = pa | ab_phase_chop;
  wire nb = pb | ab_phase_chop;
  wire nc = pc | cd_phase_chop;
  wire nd = pd | cd_phase_chop;
  wire ab_dis = (pa | pb) & ~ab_inh_chop;
  wire cd_dis = (pc | pd) & ~cd_inh_chop;

  drive_type next_drive;
  always_comb begin
    next_drive = '0;
    if (en_s) begin
      next_drive.phases = {na, nb, nc, nd};
      next_drive.ab_pair_disable_n = ab_dis;
      next_drive.cd_pair_disable_n = cd_dis;
    end
  end

  wire at_home = (translator_phases == home_pattern);

  // origin open collector: oe high pulls the pin low, so release it at home; osc_sq drives sync o, sync oe follows sync_master
  pin_drive_type next_sync;
  pin_drive_type next_origin;
  assign next_sync.o = osc_sq;
  assign next_sync.oe = sync_master;
  assign next_origin.o = 1'b0;
  assign next_origin.oe = ~at_home;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phases <= '0;
      ab_pair_disable_n <= 1'b0;
      cd_pair_disable_n <= 1'b0;
      sync_o <= 1'b0;
      sync_oe <= 1'b0;
      origin_o <= 1'b0;
      origin_oe <= 1'b0;
    end else begin
      phases <= next_drive.phases;
      ab_pair_disable_n <= next_drive.ab_pair_disable_n;
      cd_pair_disable_n <= next_drive.cd_pair_disable_n;
      sync_o <= next_sync.o;
      sync_oe <= next_sync.oe;
      origin_o <= next_origin.o;
      origin_oe <= next_origin.oe;
    end
  end

  // step doubler: ghost pulse a fixed delay after the latest input step
  logic [31:0] ghost_cnt;
  logic ghost_busy;
  logic step_d;
  wire step_rise = step_in & ~step_d;
  wire ghost_fire = ghost_busy && (ghost_cnt >= ghost_delay_cycles - 1);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      step_d <= 1'b0;
      ghost_cnt <= '0;
      ghost_busy <= 1'b0;
      step_out <= 1'b0;
    end else begin
      step_d <= step_in;
      step_out <= step_rise | (doubler_on & ghost_fire);
      if (doubler_on && step_rise) begin
        ghost_busy <= 1'b1;
        ghost_cnt <= '0;
      end else if (ghost_fire) begin
        ghost_busy <= 1'b0;
      end else if (ghost_busy) begin
        ghost_cnt <= ghost_cnt + 32'h0000_0001;
      end
    end
  end

  // unipolar AND gates live outside; nothing here depends on them
  property p_enable_off;
    @(posedge clk) disable iff (!rst_n)
      !en_s |=> (phases == 4'h0 && !ab_pair_disable_n && !cd_pair_disable_n);
  endproperty
  a_enable_off: assert property (p_enable_off) else $error("outputs not low while disabled");

  property p_origin;
    @(posedge clk) disable iff (!rst_n)
      at_home |=> !origin_oe;
  endproperty
  a_origin: assert property (p_origin) else $error("origin not released at home");

  property p_ab_idle;
    @(posedge clk) disable iff (!rst_n)
      (en_s && !pa && !pb) |=> !ab_pair_disable_n;
  endproperty
  a_ab_idle: assert property (p_ab_idle) else $error("ab disable high with pair idle");

  property p_inh_chop;
    @(posedge clk) disable iff (!rst_n)
      (!ctl_s && !ab_chop_on) |=> !ab_pair_disable_n;
  endproperty
  a_inh_chop: assert property (p_inh_chop) else $error("ab line not chopped");

  property p_cd_active;
    @(posedge clk) disable iff (!rst_n)
      (en_s && (pc || pd) && cd_chop_on) |=> cd_pair_disable_n;
  endproperty
  a_cd_active: assert property (p_cd_active) else $error("cd disable low while driven");

  property p_trip;
    @(posedge clk) disable iff (!rst_n)
      ab_trip |=> !ab_chop_on;
  endproperty
  a_trip: assert property (p_trip) else $error("ab chopper not reset by trip");

  property p_phase_chop;
    @(posedge clk) disable iff (!rst_n)
      (en_s && ctl_s && !cd_chop_on) |=> (phases[1:0] == 2'h3);
  endproperty
  a_phase_chop: assert property (p_phase_chop) else $error("cd phases not chopped");

  property p_sync_out;
    @(posedge clk) disable iff (!rst_n)
      sync_master |=> sync_oe;
  endproperty
  a_sync_out: assert property (p_sync_out) else $error("master not driving sync");

  property p_ab_active;
    @(posedge clk) disable iff (!rst_n)
      (en_s && (pa || pb) && ab_chop_on) |=> ab_pair_disable_n;
  endproperty
  a_ab_active: assert property (p_ab_active) else $error("ab disable low while driven");

  property p_follow;
    @(posedge clk) disable iff (!rst_n)
      (en_s && ab_chop_on && cd_chop_on) |=> (phases == $past(translator_phases));
  endproperty
  a_follow: assert property (p_follow) else $error("phases not following");

  // set path in two steps: a clock pulse with no trip, then the flop on
  sequence s_ab_set;
    chop_pulse && !ab_trip;
  endsequence
  sequence s_ab_enabled;
    ab_chop_on;
  endsequence
  property p_chop_set;
    @(posedge clk) disable iff (!rst_n)
      s_ab_set |=> s_ab_enabled;
  endproperty
  a_chop_set: assert property (p_chop_set) else $error("ab chopper not set");

  property p_cd_hold;
    @(posedge clk) disable iff (!rst_n)
      (cd_chop_on && !cd_trip) |=> cd_chop_on;
  endproperty
  a_cd_hold: assert property (p_cd_hold) else $error("cd chopper dropped");

  property p_osc_toggle;
    @(posedge clk) disable iff (!rst_n)
      osc_wrap |=> (osc_sq != $past(osc_sq));
  endproperty
  a_osc_toggle: assert property (p_osc_toggle) else $error("oscillator stuck");

  property p_ghost;
    @(posedge clk) disable iff (!rst_n)
      (doubler_on && ghost_fire) |=> step_out;
  endproperty
  a_ghost: assert property (p_ghost) else $error("ghost step pulse missing");
endmodule

// ==== sim/bridge_model.sv ====
// power bridge stand-in: and-gated windings with a sense comparator per pair
// assumes phase and disable lines come straight from the output stage
`timescale 1ns/1ps
module bridge_model #(
  parameter int unsigned trip_cycles = 6
) (
  // clock
  input wire logic clk,
  // from output stage
  input wire logic [3:0] phases,
  input wire logic ab_pair_disable_n,
  input wire logic cd_pair_disable_n,
  // motor connected per pair {ab, cd}
  input wire logic [1:0] load,
  // comparator outputs
  output logic ab_current_sense,
  output logic cd_current_sense
);
  logic [3:0] gated;
  int unsigned ab_cnt = 0;
  int unsigned cd_cnt = 0;
  assign gated = phases & {{2{ab_pair_disable_n}}, {2{cd_pair_disable_n}}};
  // current builds only while one side of a winding is driven; both high recirculates
  always @(posedge clk) begin
    ab_cnt <= (load[1] && (gated[3] ^ gated[2])) ? ab_cnt + 1 : 0;
    cd_cnt <= (load[0] && (gated[1] ^ gated[0])) ? cd_cnt + 1 : 0;
  end
  assign ab_current_sense = ab_cnt >= trip_cycles;
  assign cd_current_sense = cd_cnt >= trip_cycles;
endmodule

// ==== sim/stepper_phase_output_logic_bench.sv ====
// bench for the stepper output stage with a bridge model on its far side
// assumes short oscillator and ghost counts so chopping shows within tens of cycles
`timescale 1ns/1ps
module stepper_phase_output_logic_bench;
  import step_out_pkg::*;
  logic clk = 0, rst_n = 0, step_in = 0, enable_pin = 0, control_pin = 0;
  logic sync_master = 1, sync_in = 0, step_out, ab_pair_disable_n, cd_pair_disable_n;
  logic ab_current_sense, cd_current_sense, sync_o, sync_oe, origin_o, origin_oe;
  logic [3:0] translator_phases = home_pattern, phases;
  logic [1:0] load = 2'b00;
  drive_type d;
  int n_fail = 0, num_checks = 0, ab_lo, ab_up, cd_lo, ph_d, sy_ch, st;
  assign d = {phases, ab_pair_disable_n, cd_pair_disable_n};
  always #5 clk = ~clk;
  stepper_phase_output_logic #(.osc_half_cycles(4), .ghost_delay_cycles(8), .doubler_on(1'b1))
    i_stepper_phase_output_logic (.clk(clk), .rst_n(rst_n),
    .translator_phases(translator_phases), .step_in(step_in), .step_out(step_out),
    .enable_pin(enable_pin), .control_pin(control_pin), .ab_current_sense(ab_current_sense),
    .cd_current_sense(cd_current_sense), .sync_master(sync_master), .sync_in(sync_in),
    .phases(phases), .ab_pair_disable_n(ab_pair_disable_n),
    .cd_pair_disable_n(cd_pair_disable_n), .sync_o(sync_o), .sync_oe(sync_oe),
    .origin_o(origin_o), .origin_oe(origin_oe));
  bridge_model i_bridge_model (.clk(clk), .phases(phases),
    .ab_pair_disable_n(ab_pair_disable_n), .cd_pair_disable_n(cd_pair_disable_n),
    .load(load), .ab_current_sense(ab_current_sense), .cd_current_sense(cd_current_sense));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // pins pass a synchronizer, so every change is given 8 edges to land
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // counts events over n cycles; external sync toggles every 5 cycles
  task automatic watch(input int n);
    logic pa, ps;
    ab_lo = 0; ab_up = 0; cd_lo = 0; ph_d = 0; sy_ch = 0; st = 0;
    pa = ab_pair_disable_n;
    ps = sync_o;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (i % 5 == 0) sync_in <= ~sync_in;
      #1;
      ab_lo += !ab_pair_disable_n;
      ab_up += ab_pair_disable_n && !pa;
      cd_lo += !cd_pair_disable_n;
      ph_d += phases == 4'hD;
      sy_ch += sync_o != ps;
      st += step_out;
      pa = ab_pair_disable_n;
      ps = sync_o;
    end
  endtask

  initial begin
    #50000;
    n_fail++;
    finish_test;
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    enable_pin <= 1;
    cyc(10);
    check(d, {home_pattern, 2'b11});
    check({origin_o, origin_oe}, 2'b00);
    @(posedge clk) translator_phases <= 4'h8;
    cyc(3);
    check(d, {4'h8, 2'b10});
    check({origin_o, origin_oe}, 2'b01);
    @(posedge clk) translator_phases <= 4'h2;
    cyc(3);
    check(d, {4'h2, 2'b01});
    check(ab_pair_disable_n, 1'b0);
    check(phases, 4'h2);
    $display("test static levels done");
    @(posedge clk) load <= 2'b11;
    enable_pin <= 0;
    translator_phases <= 4'h9;
    cyc(8);
    watch(40);
    check(ab_lo + cd_lo, 80);
    check(ph_d + ab_up, 0);
    check(d, 8'h00);
    $display("test enable gating done");
    @(posedge clk) load <= 2'b10;
    enable_pin <= 1;
    cyc(8);
    watch(80);
    check(ab_up > 1, 1);
    check(cd_lo, 0);
    check(ph_d, 0);
    $display("test inhibit chopping done");
    @(posedge clk) control_pin <= 1;
    cyc(8);
    watch(80);
    check(ab_lo, 0);
    check(ph_d > 1, 1);
    check(sy_ch, 20);
    check(sync_oe, 1);
    $display("test phase chopping done");
    @(posedge clk) control_pin <= 0;
    sync_master <= 0;
    cyc(8);
    watch(80);
    check(sync_oe, 0);
    check(ab_up > 1, 1);
    $display("test external sync done");
    @(posedge clk) load <= 2'b00;
    step_in <= 1;
    watch(30);
    check(st, 2);
    $display("test step doubler done");
    finish_test;
  end
endmodule
